// ---- include/audio_path_pkg.sv ----
// Offsets, field positions and reset values of the upper audio control bank
package audio_path_pkg;

    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [8:0] OFF_ADC_GAIN_CLOCK = 9'h18d;
    localparam logic [8:0] OFF_VOICE_DAC      = 9'h18e;
    localparam logic [8:0] OFF_LEFT_DAC       = 9'h18f;
    localparam logic [8:0] OFF_RIGHT_DAC      = 9'h190;
    localparam logic [8:0] OFF_LEFT_MIXER     = 9'h191;
    localparam logic [8:0] OFF_RIGHT_MIXER    = 9'h192;
    localparam logic [8:0] OFF_RIGHT_SIDETONE = 9'h193;
    localparam logic [8:0] OFF_LEFT_SIDETONE  = 9'h194;
    localparam logic [8:0] OFF_AMP_ENABLES    = 9'h195;
    localparam logic [8:0] OFF_CONV_ENABLES   = 9'h196;
    localparam logic [8:0] OFF_ACC_STATUS     = 9'h197;
    localparam logic [8:0] OFF_ACC_MASK       = 9'h198;
    localparam logic [8:0] OFF_TRIM           = 9'h199;

    // Writable-bit masks; reserved bits are zero here
    localparam logic [7:0] WMASK_ADC_GAIN_CLOCK = 8'h7f;
    localparam logic [7:0] WMASK_VOLUME_MUTE    = 8'hbf;
    localparam logic [7:0] WMASK_LEFT_MIXER     = 8'hb7;
    localparam logic [7:0] WMASK_RIGHT_MIXER    = 8'h6e;
    localparam logic [7:0] WMASK_SIDETONE       = 8'h3f;
    localparam logic [7:0] WMASK_AMP_ENABLES    = 8'hdf;
    localparam logic [7:0] WMASK_CONV_ENABLES   = 8'hff;
    localparam logic [7:0] WMASK_ACC_MASK       = 8'h0f;
    localparam logic [7:0] WMASK_TRIM           = 8'h03;

    // Reset values
    localparam logic [7:0] RST_CTRL   = 8'h00;
    localparam logic [7:0] RST_STATUS = 8'h00;

    // Field positions
    localparam int GAIN_STEP_LSB  = 0;
    localparam int GAIN_EN_BIT    = 3;
    localparam int CLK_SEL_LSB    = 4;
    localparam int VOL_LSB        = 0;
    localparam int MUTE_BIT       = 7;
    localparam int FLAG_LONG      = 0;
    localparam int FLAG_MOMENTARY = 1;
    localparam int FLAG_HEADPHONE = 2;
    localparam int FLAG_HEADSET   = 3;
    localparam int NUM_FLAGS      = 4;

    // Stereo input clock select after reset stands for the 26 MHz reference
    localparam logic [2:0] CLK_SEL_26MHZ = 3'h0;

endpackage

// ---- rtl/audio_path_control_regs.sv ----
// Upper audio control register bank: volumes, mixers, enables, accessory events
//
// How it works
// [R1] ADC gain step, enable, clock select fields
// [R2] Voice DAC six-bit volume, mute bit seven
// [R3] Left DAC volume and mute at 0x18f
// [R4] Right DAC volume and mute at 0x190
// [R5] Earpiece, headset right/left mutes at 0x191
// [R6] Left mixer selects stereo, voice, line
// [R7] Speaker right/left mutes at 0x192
// [R8] Right mixer selects stereo, voice, line
// [R9] Side-tone six-bit volumes, upper bits reserved
// [R10] Output amplifier enables at 0x195
// [R11] Converter enables and bus drive strength
// [R12] Read-only accessory status flags
// [R13] Headphone and headset flags both read direct, uninverted
// [R14] Per-source masks; one suppresses interrupt
// [R15] Status read clears headphone and summary
// [R16] Reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module audio_path_control_regs
    import audio_path_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Serial host port, already deserialised into register accesses
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    // Accessory detector event pulses
    input  wire logic              long_push_event,
    input  wire logic              momentary_push_event,
    input  wire logic              headphone_event,
    input  wire logic              headset_event,
    // Stereo ADC controls
    output logic      [2:0]        stereo_adc_gain_step,
    output logic                   stereo_adc_gain_enable,
    output logic      [2:0]        stereo_input_clock_select,
    // DAC volumes and mutes
    output logic      [5:0]        voice_dac_volume_code,
    output logic                   voice_dac_mute,
    output logic      [5:0]        left_dac_volume_code,
    output logic                   left_dac_mute,
    output logic      [5:0]        right_dac_volume_code,
    output logic                   right_dac_mute,
    // Amplifier mutes
    output logic                   earpiece_mute,
    output logic                   headset_right_mute,
    output logic                   headset_left_mute,
    output logic                   speaker_right_mute,
    output logic                   speaker_left_mute,
    // Mixer selects
    output logic                   left_mix_stereo_dac,
    output logic                   left_mix_voice_dac,
    output logic                   left_mix_line_in,
    output logic                   right_mix_stereo_dac,
    output logic                   right_mix_voice_dac,
    output logic                   right_mix_line_in,
    // Side-tone levels
    output logic      [5:0]        right_sidetone_level,
    output logic      [5:0]        left_sidetone_level,
    // Amplifier and converter enables
    output logic                   earpiece_amp_on,
    output logic                   headphone_right_amp_on,
    output logic                   headphone_left_amp_on,
    output logic                   lineout_right_amp_on,
    output logic                   lineout_left_amp_on,
    output logic                   speaker_right_amp_on,
    output logic                   speaker_left_amp_on,
    output logic                   voice_adc_on,
    output logic                   stereo_adc_on,
    output logic                   mic2_amp_on,
    output logic                   mic1_amp_on,
    output logic                   stereo_dac_on,
    output logic                   voice_dac_on,
    output logic      [1:0]        bus_drive_strength,
    // Trim and summary audio interrupt
    output logic      [1:0]        trim_offset_on,
    output logic                   audio_irq
);

    logic [7:0] q_gain;
    logic [7:0] q_voice;
    logic [7:0] q_left;
    logic [7:0] q_right;
    logic [7:0] q_lmix;
    logic [7:0] q_rmix;
    logic [7:0] q_rside;
    logic [7:0] q_lside;
    logic [7:0] q_amps;
    logic [7:0] q_conv;
    logic [7:0] q_mask;
    logic [7:0] q_trim;
    logic [NUM_FLAGS-1:0] flags;
    logic [NUM_FLAGS-1:0] event_vec;
    logic       status_read;
    logic       summary;
    logic [7:0] next_rdata;

    assign status_read = reg_rd && (reg_addr == OFF_ACC_STATUS);
    assign event_vec   = {headset_event, headphone_event, momentary_push_event, long_push_event};

    // Control bytes, each with its reserved bits masked off
    reg_byte #(.WMASK(WMASK_ADC_GAIN_CLOCK), .RVAL(RST_CTRL)) u_gain (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_ADC_GAIN_CLOCK),
        .wdata(reg_wdata), .q(q_gain)); // R1
    reg_byte #(.WMASK(WMASK_VOLUME_MUTE), .RVAL(RST_CTRL)) u_voice (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_VOICE_DAC),
        .wdata(reg_wdata), .q(q_voice)); // R2
    reg_byte #(.WMASK(WMASK_VOLUME_MUTE), .RVAL(RST_CTRL)) u_left (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_LEFT_DAC),
        .wdata(reg_wdata), .q(q_left)); // R3
    reg_byte #(.WMASK(WMASK_VOLUME_MUTE), .RVAL(RST_CTRL)) u_right (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_RIGHT_DAC),
        .wdata(reg_wdata), .q(q_right)); // R4
    reg_byte #(.WMASK(WMASK_LEFT_MIXER), .RVAL(RST_CTRL)) u_lmix (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_LEFT_MIXER),
        .wdata(reg_wdata), .q(q_lmix)); // R5
    reg_byte #(.WMASK(WMASK_RIGHT_MIXER), .RVAL(RST_CTRL)) u_rmix (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_RIGHT_MIXER),
        .wdata(reg_wdata), .q(q_rmix)); // R7
    reg_byte #(.WMASK(WMASK_SIDETONE), .RVAL(RST_CTRL)) u_rside (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_RIGHT_SIDETONE),
        .wdata(reg_wdata), .q(q_rside)); // R9
    reg_byte #(.WMASK(WMASK_SIDETONE), .RVAL(RST_CTRL)) u_lside (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_LEFT_SIDETONE),
        .wdata(reg_wdata), .q(q_lside)); // R9
    reg_byte #(.WMASK(WMASK_AMP_ENABLES), .RVAL(RST_CTRL)) u_amps (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_AMP_ENABLES),
        .wdata(reg_wdata), .q(q_amps)); // R10
    reg_byte #(.WMASK(WMASK_CONV_ENABLES), .RVAL(RST_CTRL)) u_conv (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_CONV_ENABLES),
        .wdata(reg_wdata), .q(q_conv)); // R11
    reg_byte #(.WMASK(WMASK_ACC_MASK), .RVAL(RST_CTRL)) u_mask (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_ACC_MASK),
        .wdata(reg_wdata), .q(q_mask)); // R14
    reg_byte #(.WMASK(WMASK_TRIM), .RVAL(RST_CTRL)) u_trim (
        .clk_sys(clk_sys), .rst(rst), .wr(reg_wr && reg_addr == OFF_TRIM),
        .wdata(reg_wdata), .q(q_trim)); // R16

    // Accessory event flags; the status register itself cannot be written
    event_flags u_flags (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .event_set (event_vec),
        .rd_clear  (status_read),
        .flags     (flags)
    ); // R12

    // Summary interrupt is sticky: set by any unmasked event, cleared by a status read.
    // Masking suppresses the event rather than hiding a flag already raised.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            summary <= 1'b0;
        end else if (|(event_vec & ~q_mask[NUM_FLAGS-1:0])) begin
            summary <= 1'b1; // R14
        end else if (status_read) begin
            summary <= 1'b0; // R15
        end
    end

    // Read data selection; unmapped offsets and reserved bits return zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == OFF_ADC_GAIN_CLOCK) begin
            next_rdata = q_gain;
        end else if (reg_addr == OFF_VOICE_DAC) begin
            next_rdata = q_voice;
        end else if (reg_addr == OFF_LEFT_DAC) begin
            next_rdata = q_left;
        end else if (reg_addr == OFF_RIGHT_DAC) begin
            next_rdata = q_right;
        end else if (reg_addr == OFF_LEFT_MIXER) begin
            next_rdata = q_lmix;
        end else if (reg_addr == OFF_RIGHT_MIXER) begin
            next_rdata = q_rmix;
        end else if (reg_addr == OFF_RIGHT_SIDETONE) begin
            next_rdata = q_rside;
        end else if (reg_addr == OFF_LEFT_SIDETONE) begin
            next_rdata = q_lside;
        end else if (reg_addr == OFF_AMP_ENABLES) begin
            next_rdata = q_amps;
        end else if (reg_addr == OFF_CONV_ENABLES) begin
            next_rdata = q_conv;
        end else if (reg_addr == OFF_ACC_STATUS) begin
            next_rdata = {4'h0, flags}; // R13
        end else if (reg_addr == OFF_ACC_MASK) begin
            next_rdata = q_mask;
        end else if (reg_addr == OFF_TRIM) begin
            next_rdata = q_trim; // R16
        end
    end

    // Read data registered one cycle after the strobe; held between reads
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // Field outputs, registered so each pin comes from a flip-flop (one cycle behind the byte)
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stereo_adc_gain_step      <= 3'h0;
            stereo_adc_gain_enable    <= 1'b0;
            stereo_input_clock_select <= CLK_SEL_26MHZ;
            voice_dac_volume_code     <= 6'h00;
            voice_dac_mute            <= 1'b0;
            left_dac_volume_code      <= 6'h00;
            left_dac_mute             <= 1'b0;
            right_dac_volume_code     <= 6'h00;
            right_dac_mute            <= 1'b0;
        end else begin
            stereo_adc_gain_step      <= q_gain[GAIN_STEP_LSB +: 3]; // R1
            stereo_adc_gain_enable    <= q_gain[GAIN_EN_BIT]; // R1
            stereo_input_clock_select <= q_gain[CLK_SEL_LSB +: 3]; // R1
            voice_dac_volume_code     <= q_voice[VOL_LSB +: 6]; // R2
            voice_dac_mute            <= q_voice[MUTE_BIT]; // R2
            left_dac_volume_code      <= q_left[VOL_LSB +: 6]; // R3
            left_dac_mute             <= q_left[MUTE_BIT]; // R3
            right_dac_volume_code     <= q_right[VOL_LSB +: 6]; // R4
            right_dac_mute            <= q_right[MUTE_BIT]; // R4
        end
    end

    // Mutes, mixer selects and side-tone levels
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            earpiece_mute        <= 1'b0;
            headset_right_mute   <= 1'b0;
            headset_left_mute    <= 1'b0;
            speaker_right_mute   <= 1'b0;
            speaker_left_mute    <= 1'b0;
            left_mix_stereo_dac  <= 1'b0;
            left_mix_voice_dac   <= 1'b0;
            left_mix_line_in     <= 1'b0;
            right_mix_stereo_dac <= 1'b0;
            right_mix_voice_dac  <= 1'b0;
            right_mix_line_in    <= 1'b0;
            right_sidetone_level <= 6'h00;
            left_sidetone_level  <= 6'h00;
        end else begin
            earpiece_mute        <= q_lmix[0]; // R5
            headset_right_mute   <= q_lmix[1]; // R5
            headset_left_mute    <= q_lmix[2]; // R5
            left_mix_stereo_dac  <= q_lmix[4]; // R6
            left_mix_voice_dac   <= q_lmix[5]; // R6
            left_mix_line_in     <= q_lmix[7]; // R6
            speaker_right_mute   <= q_rmix[1]; // R7
            speaker_left_mute    <= q_rmix[2]; // R7
            right_mix_stereo_dac <= q_rmix[3]; // R8
            right_mix_voice_dac  <= q_rmix[5]; // R8
            right_mix_line_in    <= q_rmix[6]; // R8
            right_sidetone_level <= q_rside[5:0]; // R9
            left_sidetone_level  <= q_lside[5:0]; // R9
        end
    end

    // Power enables, drive strength, trim and interrupt pin
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            earpiece_amp_on        <= 1'b0;
            headphone_right_amp_on <= 1'b0;
            headphone_left_amp_on  <= 1'b0;
            lineout_right_amp_on   <= 1'b0;
            lineout_left_amp_on    <= 1'b0;
            speaker_right_amp_on   <= 1'b0;
            speaker_left_amp_on    <= 1'b0;
            voice_adc_on           <= 1'b0;
            stereo_adc_on          <= 1'b0;
            mic2_amp_on            <= 1'b0;
            mic1_amp_on            <= 1'b0;
            stereo_dac_on          <= 1'b0;
            voice_dac_on           <= 1'b0;
            bus_drive_strength     <= 2'h0;
            trim_offset_on         <= 2'h0;
            audio_irq              <= 1'b0;
        end else begin
            earpiece_amp_on        <= q_amps[0]; // R10
            headphone_right_amp_on <= q_amps[1]; // R10
            headphone_left_amp_on  <= q_amps[2]; // R10
            lineout_right_amp_on   <= q_amps[3]; // R10
            lineout_left_amp_on    <= q_amps[4]; // R10
            speaker_right_amp_on   <= q_amps[6]; // R10
            speaker_left_amp_on    <= q_amps[7]; // R10
            voice_adc_on           <= q_conv[0]; // R11
            stereo_adc_on          <= q_conv[1]; // R11
            mic2_amp_on            <= q_conv[2]; // R11
            mic1_amp_on            <= q_conv[3]; // R11
            stereo_dac_on          <= q_conv[4]; // R11
            voice_dac_on           <= q_conv[5]; // R11
            bus_drive_strength     <= q_conv[7:6]; // R11
            trim_offset_on         <= q_trim[1:0];
            audio_irq              <= summary; // R14
        end
    end

endmodule
`default_nettype wire

// ---- rtl/event_flags.sv ----
// Sticky accessory event flags with read-to-clear of the headphone flag
`timescale 1ns/1ps
`default_nettype none
module event_flags
    import audio_path_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    // Event pulse of each source
    input  wire logic [NUM_FLAGS-1:0] event_set,
    // Clear request from a status read
    input  wire logic                 rd_clear,
    // Flag state
    output logic      [NUM_FLAGS-1:0] flags
);

    // A set in the clear cycle wins, so no event is lost
    genvar i;
    generate
        for (i = 0; i < NUM_FLAGS; i++) begin : g_flag
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    flags[i] <= 1'b0;
                end else if (event_set[i]) begin
                    flags[i] <= 1'b1;
                end else if (rd_clear && i == FLAG_HEADPHONE) begin
                    flags[i] <= 1'b0; // R15
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// ---- rtl/reg_byte.sv ----
// One writable control byte with a write mask and reset value
`timescale 1ns/1ps
`default_nettype none
module reg_byte
    import audio_path_pkg::*;
#(
    parameter logic [7:0] WMASK = 8'hff,
    parameter logic [7:0] RVAL  = 8'h00
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Write port
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    // Stored value
    output logic      [7:0] q
);

    // Reserved bits never store, so they read as zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= RVAL & WMASK;
        end else if (wr) begin
            q <= wdata & WMASK; // R16
        end
    end

endmodule
`default_nettype wire

// ---- testbench/audio_path_control_regs_asserts.sv ----
// Checker for the upper audio control bank: writes, reads and accessory events
`timescale 1ns/1ps
`default_nettype none
module audio_path_control_regs_asserts
    import audio_path_pkg::*;
(
    // Clock, reset and host port
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Accessory events and summary
    input wire logic       long_push_event,
    input wire logic       momentary_push_event,
    input wire logic       headphone_event,
    input wire logic       headset_event,
    input wire logic       audio_irq,
    // Watched fields
    input wire logic [5:0] voice_dac_volume_code,
    input wire logic       voice_dac_mute,
    input wire logic [5:0] left_dac_volume_code,
    input wire logic       left_dac_mute,
    input wire logic [5:0] right_dac_volume_code,
    input wire logic       right_dac_mute,
    input wire logic [5:0] right_sidetone_level
);
    logic [3:0] mask_q;
    logic       quiet;
    logic       mask_wr;

    // Shadow of the event mask, since the register itself is not a port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mask_q <= 4'h0;
        end else if (mask_wr) begin
            mask_q <= reg_wdata[3:0];
        end
    end

    // Mask writes are excluded from irq checks: old or new mask may apply
    assign mask_wr = reg_wr && reg_addr == OFF_ACC_MASK;
    assign quiet = !(long_push_event || momentary_push_event || headphone_event || headset_event);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // A single write to one offset, not overwritten in the next cycle
    sequence s_wr_once(logic [8:0] a);
        reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
    endsequence
    sequence s_rd_status;
        reg_rd && reg_addr == OFF_ACC_STATUS;
    endsequence

    a_voice_dac_write: assert property (
        s_wr_once(OFF_VOICE_DAC) |=> {voice_dac_mute, 1'b0, voice_dac_volume_code} == ($past(reg_wdata, 2) & 8'hbf))
        else $error("voice DAC write lost");
    a_left_dac_write: assert property (
        s_wr_once(OFF_LEFT_DAC) |=> {left_dac_mute, 1'b0, left_dac_volume_code} == ($past(reg_wdata, 2) & 8'hbf))
        else $error("left DAC write lost");
    a_right_dac_write: assert property (
        s_wr_once(OFF_RIGHT_DAC) |=> {right_dac_mute, 1'b0, right_dac_volume_code} == ($past(reg_wdata, 2) & 8'hbf))
        else $error("right DAC write lost");
    a_sidetone_write: assert property (
        s_wr_once(OFF_RIGHT_SIDETONE) |=> right_sidetone_level == $past(reg_wdata[5:0], 2))
        else $error("side-tone write lost");
    a_unmapped_read: assert property (
        reg_rd && (reg_addr < OFF_ADC_GAIN_CLOCK || reg_addr > OFF_TRIM) |=> reg_rdata == 8'h00)
        else $error("unmapped read nonzero");
    a_status_reserved: assert property (
        s_rd_status |=> reg_rdata[7:4] == 4'h0)
        else $error("status reserved bits set");
    a_event_raises_irq: assert property (
        headphone_event && !mask_q[2] && !mask_wr |-> ##2 audio_irq)
        else $error("headphone irq missing");
    a_masked_quiet: assert property (
        (mask_q == 4'hf && !mask_wr) ##1 !audio_irq |=> !audio_irq)
        else $error("irq while all masked");
    a_read_clears_irq: assert property (
        reg_rd && reg_addr == OFF_ACC_STATUS && quiet |-> ##2 !audio_irq)
        else $error("irq not cleared by read");
endmodule

bind audio_path_control_regs audio_path_control_regs_asserts u_asserts (
    .clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .long_push_event, .momentary_push_event, .headphone_event, .headset_event, .audio_irq,
    .voice_dac_volume_code, .voice_dac_mute, .left_dac_volume_code, .left_dac_mute,
    .right_dac_volume_code, .right_dac_mute, .right_sidetone_level
);
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the upper audio control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb
    import audio_path_pkg::*;
;
    // Stimulus, all driven on the falling edge
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [8:0] reg_addr = 9'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic [3:0] ev = 4'h0;
    // Observed outputs
    logic [7:0] reg_rdata;
    logic [5:0] voice_dac_volume_code, left_dac_volume_code, right_dac_volume_code;
    logic [5:0] right_sidetone_level, left_sidetone_level;
    logic [2:0] stereo_adc_gain_step, stereo_input_clock_select;
    logic [1:0] bus_drive_strength, trim_offset_on;
    logic       stereo_adc_gain_enable, voice_dac_mute, left_dac_mute, right_dac_mute, audio_irq;
    logic       earpiece_mute, headset_right_mute, headset_left_mute, speaker_right_mute, speaker_left_mute;
    logic       left_mix_stereo_dac, left_mix_voice_dac, left_mix_line_in;
    logic       right_mix_stereo_dac, right_mix_voice_dac, right_mix_line_in;
    logic       earpiece_amp_on, headphone_right_amp_on, headphone_left_amp_on, lineout_right_amp_on;
    logic       lineout_left_amp_on, speaker_right_amp_on, speaker_left_amp_on, voice_adc_on;
    logic       stereo_adc_on, mic2_amp_on, mic1_amp_on, stereo_dac_on, voice_dac_on;
    int         n_mismatch = 0;
    int         compares = 0;
    logic [7:0] got;
    // Bits that keep a written one, offsets 0x18d upward; status is read-only
    logic [7:0] rw_bits [13] = '{8'h7f, 8'hbf, 8'hbf, 8'hbf, 8'hb7, 8'h6e, 8'h3f,
        8'h3f, 8'hdf, 8'hff, 8'h00, 8'h0f, 8'h03};

    audio_path_control_regs dut_u (
        .*, .long_push_event(ev[0]), .momentary_push_event(ev[1]), .headphone_event(ev[2]), .headset_event(ev[3])
    );

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    // One-cycle strobes; each access leaves an idle cycle behind it
    task wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    task rd(input logic [8:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk_sys);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask

    task pulse(input int i);
        @(negedge clk_sys);
        ev[i] = 1'b1;
        @(negedge clk_sys);
        ev = 4'h0;
    endtask

    task print_verdict();
        $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Six-cycle reset, then every register reads cleared; also wipes sticky flags
    task t_reset();
        rst = 1'b1;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        for (int i = 0; i < 13; i++) begin
            rd(9'h18d + 9'(i), got);
            `CHK("reset value", 8'h00, got)
        end
        `CHK("irq after reset", 1'b0, audio_irq)
        $display("test reset done");
    endtask

    // Ones then zeros into each offset; reserved and read-only bits must not stick
    task t_readback();
        for (int i = 0; i < 13; i++) begin
            wr(9'h18d + 9'(i), 8'hff);
            rd(9'h18d + 9'(i), got);
            `CHK("writable bits", rw_bits[i], got)
            wr(9'h18d + 9'(i), 8'h00);
            rd(9'h18d + 9'(i), got);
            `CHK("cleared bits", 8'h00, got)
        end
        wr(9'h19a, 8'hff);
        rd(9'h19a, got);
        `CHK("unmapped above", 8'h00, got)
        rd(9'h18c, got);
        `CHK("unmapped below", 8'h00, got)
        $display("test readback done");
    endtask

    // Distinct patterns per register, then every field output is compared
    task t_fields();
        logic [7:0] fd [11] = '{8'h5b, 8'hc5, 8'h2a, 8'hbf, 8'ha9, 8'h4b, 8'hd5, 8'h6a, 8'ha5, 8'h9a, 8'hfe};
        for (int i = 0; i < 11; i++) begin
            wr(i < 10 ? 9'h18d + 9'(i) : OFF_TRIM, fd[i]);
        end
        @(negedge clk_sys);
        `CHK("adc gain", 7'h5b, {stereo_input_clock_select, stereo_adc_gain_enable, stereo_adc_gain_step})
        `CHK("voice dac", 7'h45, {voice_dac_mute, voice_dac_volume_code})
        `CHK("left dac", 7'h2a, {left_dac_mute, left_dac_volume_code})
        `CHK("right dac", 7'h7f, {right_dac_mute, right_dac_volume_code})
        got = {2'b00, left_mix_line_in, left_mix_voice_dac, left_mix_stereo_dac, headset_left_mute,
               headset_right_mute, earpiece_mute};
        `CHK("left mixer", 8'h31, got)
        got = {3'b000, right_mix_line_in, right_mix_voice_dac, right_mix_stereo_dac, speaker_left_mute,
               speaker_right_mute};
        `CHK("right mixer", 8'h15, got)
        `CHK("sidetone", 12'h56a, {right_sidetone_level, left_sidetone_level})
        got = {1'b0, speaker_left_amp_on, speaker_right_amp_on, lineout_left_amp_on, lineout_right_amp_on,
               headphone_left_amp_on, headphone_right_amp_on, earpiece_amp_on};
        `CHK("amp enables", 8'h45, got)
        got = {bus_drive_strength, voice_dac_on, stereo_dac_on, mic1_amp_on, mic2_amp_on, stereo_adc_on, voice_adc_on};
        `CHK("converter enables", 8'h9a, got)
        `CHK("trim", 2'h2, trim_offset_on)
        $display("test fields done");
    endtask

    // Masked events still flag; each source alone unmasked raises the summary
    task t_events();
        wr(OFF_ACC_MASK, 8'hff);
        for (int i = 0; i < 4; i++) begin
            pulse(i);
        end
        @(negedge clk_sys);
        `CHK("masked irq", 1'b0, audio_irq)
        rd(OFF_ACC_STATUS, got);
        `CHK("status all set", 8'h0f, got)
        rd(OFF_ACC_STATUS, got);
        `CHK("headphone flag cleared", 8'h0b, got)
        for (int i = 0; i < 4; i++) begin
            wr(OFF_ACC_MASK, 8'h0f ^ (8'h01 << i));
            pulse(i);
            @(negedge clk_sys);
            `CHK("unmasked irq", 1'b1, audio_irq)
            rd(OFF_ACC_STATUS, got);
            `CHK("status sticky", (i == 2) ? 8'h0f : 8'h0b, got)
            @(negedge clk_sys);
            `CHK("irq cleared by read", 1'b0, audio_irq)
        end
        $display("test events done");
    endtask

    // Hang guard far beyond the run length
    initial begin
        #400000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        t_reset();
        t_readback();
        t_fields();
        t_events();
        t_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
